// ### verilog/fblc_pkg.sv
// package of constants and types for the flash block lock control
package fblc_pkg;
   // ************************************************************
   // widths and timing
   // ************************************************************
   localparam int unsigned NUM_BLOCKS_DEF      = 131;
   localparam int unsigned CLK_PERIOD_NS       = 40;
   // release delay of the configuration-sync pin after supplies are good
   localparam int unsigned SYNC_RELEASE_DELAY_NS = 4000;
   localparam int unsigned SYNC_RELEASE_CYCLES =
      (SYNC_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DLY_W               = 16;
   // ************************************************************
   // command codes on the command port
   // ************************************************************
   typedef enum logic [2:0]
   {
      FBLC_CMD_NONE     = 3'h0,
      FBLC_CMD_LOCK     = 3'h1,
      FBLC_CMD_UNLOCK   = 3'h2,
      FBLC_CMD_LOCKDOWN = 3'h3,
      FBLC_CMD_PROGRAM  = 3'h4,
      FBLC_CMD_ERASE    = 3'h5
   } fblc_cmd_t;
   // operation suspend state reported by the array controller
   typedef enum logic [1:0]
   {
      FBLC_SUSP_NONE  = 2'h0,
      FBLC_SUSP_ERASE = 2'h1,
      FBLC_SUSP_PROG  = 2'h2
   } fblc_susp_t;
   // per-block flags after reset: locked, not locked down
   localparam logic FLAG_LOCK_RST     = 1'b1;
   localparam logic FLAG_LOCKDOWN_RST = 1'b0;
   // status word bit positions
   localparam int unsigned STAT_LOCK_BIT  = 0;
   localparam int unsigned STAT_LDOWN_BIT = 1;
   localparam int unsigned STAT_WP_BIT    = 2;
endpackage

// ### verilog/fblc_cmd_if.sv
// command bundle between the control top and the flag array
`timescale 1ns/100ps
`default_nettype none
interface fblc_cmd_if #(parameter int unsigned AW = 8);
   logic          cmd_valid;   // one-cycle command pulse
   logic [2:0]    cmd_code;    // command code
   logic [AW-1:0] cmd_block;   // addressed block
   logic          wp_high;     // synchronised protect level
   logic          wp_rise;     // protect pin rising pulse
   logic          wp_fall;     // protect pin falling pulse
   logic          soft_reset;  // power-down forced reset
   logic          st_lock;     // addressed block lock flag
   logic          st_ldown;    // addressed block lockdown flag
   modport ctrl (output cmd_valid, cmd_code, cmd_block, wp_high, wp_rise, wp_fall,
                 soft_reset, input st_lock, st_ldown);
   modport arr  (input cmd_valid, cmd_code, cmd_block, wp_high, wp_rise, wp_fall,
                 soft_reset, output st_lock, st_ldown);
endinterface
`default_nettype wire

// ### verilog/fblc_flag_array.sv
// per-block lock and lockdown flag storage with protect-pin behaviour
`timescale 1ns/100ps
`default_nettype none
module fblc_flag_array
   import fblc_pkg::*;
#(
   parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF,
   parameter int unsigned AW         = 8
)
(
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   // command side
   fblc_cmd_if.arr     cif
);
   // ************************************************************
   // state
   // ************************************************************
   // [R1] independent flags per block
   typedef struct packed
   {
      logic [NUM_BLOCKS-1:0] lock;     // current lock flag
      logic [NUM_BLOCKS-1:0] ldown;    // lockdown flag
      logic [NUM_BLOCKS-1:0] saved;    // lock flag kept from pin-high period
      logic                  st_lock;
      logic                  st_ldown;
   } fblc_arr_t;
   fblc_arr_t s_q;
   fblc_arr_t s_d;

   // per-block next state
   always_comb
   begin
      s_d = s_q;
      for (int i = 0; i < NUM_BLOCKS; i++)
      begin
         // [R13] forced back to locked
         if (cif.soft_reset)
         begin
            s_d.lock[i]  = FLAG_LOCK_RST;
            s_d.ldown[i] = FLAG_LOCKDOWN_RST;
            s_d.saved[i] = FLAG_LOCK_RST;
         end
         // [R11] enforce lockdown on pin fall
         else if (cif.wp_fall && s_q.ldown[i])
         begin
            s_d.saved[i] = s_q.lock[i];
            s_d.lock[i]  = 1'b1;
         end
         // [R12] restore lock on pin rise
         else if (cif.wp_rise && s_q.ldown[i])
            s_d.lock[i] = s_q.saved[i];
         // [R20] only addressed block changes
         else if (cif.cmd_valid && cif.cmd_block == AW'(i))
         begin
            // [R8] frozen when locked down, pin low
            if (!(s_q.ldown[i] && !cif.wp_high))
            begin
               // [R3] lock flag commands
               if (cif.cmd_code == FBLC_CMD_LOCK)
                  s_d.lock[i] = 1'b1;
               // [R9] [R10] unlock toggles lock only
               else if (cif.cmd_code == FBLC_CMD_UNLOCK)
                  s_d.lock[i] = 1'b0;
               // [R4] lockdown sets both flags
               else if (cif.cmd_code == FBLC_CMD_LOCKDOWN)
               begin
                  s_d.ldown[i] = 1'b1;
                  s_d.lock[i]  = 1'b1;
               end
            end
         end
      end
      s_d.st_lock  = 1'b1;
      s_d.st_ldown = 1'b0;
      for (int i = 0; i < NUM_BLOCKS; i++)
      begin
         if (cif.cmd_block == AW'(i))
         begin
            s_d.st_lock  = s_d.lock[i];
            s_d.st_ldown = s_d.ldown[i];
         end
      end
   end

   // [R5] reset to locked state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q.lock     <= '1;
         s_q.ldown    <= '0;
         s_q.saved    <= '1;
         s_q.st_lock  <= 1'b1;
         s_q.st_ldown <= 1'b0;
      end
      else
         s_q <= s_d;
   end

   assign cif.st_lock  = s_q.st_lock;
   assign cif.st_ldown = s_q.st_ldown;
endmodule
`default_nettype wire

// ### verilog/fblc_sync_timer.sv
// release timer for the configuration-sync pin
`timescale 1ns/100ps
`default_nettype none
module fblc_sync_timer
   import fblc_pkg::*;
#(
   parameter int unsigned DELAY = SYNC_RELEASE_CYCLES
)
(
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   // control
   input  wire logic   hold,
   output var  logic   release_o
);
   typedef struct packed
   {
      logic [DLY_W-1:0] cnt;
      logic             rel;
   } fblc_tmr_t;
   fblc_tmr_t t_q;
   fblc_tmr_t t_d;

   // count supplies-good cycles, restart on hold
   always_comb
   begin
      t_d = t_q;
      if (hold)
      begin
         t_d.cnt = '0;
         t_d.rel = 1'b0;
      end
      else if (t_q.cnt >= DLY_W'(DELAY - 1))
         t_d.rel = 1'b1;
      else
         t_d.cnt = t_q.cnt + 1'b1;
   end

   // timer registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         t_q <= '0;
      else
         t_q <= t_d;
   end

   assign release_o = t_q.rel;
endmodule
`default_nettype wire

// ### verilog/fblc_top.sv
// top of the flash block lock control: command gating, status, sync pin
// Contract
// [R1] each block keeps its own protection state
// [R2] signature mode read returns block flags
// [R3] lock sets, unlock clears, lockdown sets lock
// [R4] lockdown flag cleared only by reset
// [R5] reset leaves every block locked
// [R6] program/erase on locked block refused, error
// [R7] unlocked block accepts program and erase
// [R8] pin low plus lockdown freezes block
// [R9] pin high lets lockdown block toggle lock
// [R10] pin high: unlock keeps lockdown flag
// [R11] pin falling re-locks lockdown blocks
// [R12] pin rising restores previous lock flag
// [R13] power-down forces all blocks locked
// [R14] lock commands accepted during erase suspend
// [R15] host suspends erase before locking
// [R16] suspended erase block updates, erase continues
// [R17] no lock commands during program suspend
// [R18] sync pin low until delay after supplies
// [R19] power-down resets and holds sync low
// [R20] commands touch only the addressed block
// [R21] protect pin sampled, edges detected once
`timescale 1ns/100ps
`default_nettype none
module fblc_top
   import fblc_pkg::*;
#(
   parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF,
   parameter int unsigned AW         = 8,
   parameter int unsigned SYNC_DELAY = SYNC_RELEASE_CYCLES
)
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   // pins and supply monitors
   input  wire logic          write_protect_n,    // protect pin level
   input  wire logic          reset_pulse_pin_n,  // external reset pulse
   input  wire logic          supplies_good,      // both supplies above threshold
   input  wire logic          power_down_threshold, // high when supply fell below
   output logic               config_sync,        // configuration-sync level
   // command port
   input  wire logic          cmd_valid,
   input  wire logic [2:0]    cmd_code,
   input  wire logic [AW-1:0] cmd_block,
   input  wire logic [1:0]    suspend_state,
   input  wire logic          sig_read_mode,      // electronic-signature mode
   // answers
   output logic               op_grant,           // program/erase allowed pulse
   output logic               op_error,           // protection error sticky
   output logic               lock_ignored,       // lock command refused pulse
   output logic [2:0]         status_word         // pin, lockdown, lock
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      logic          wp_s;        // sampled protect level
      logic          wp_prev;
      logic          pend;        // command waiting for flag lookup
      logic [2:0]    pend_code;
      logic [AW-1:0] pend_blk;
      logic          grant;
      logic          err;
      logic          ign;
      logic [2:0]    stat;
      logic          sync;
   } fblc_top_t;
   fblc_top_t s_q;
   fblc_top_t s_d;

   fblc_cmd_if #(.AW(AW)) cif ();
   logic reset_cond;
   logic released;

   // ************************************************************
   // reset sources
   // ************************************************************
   // [R19] power-down acts as reset
   assign reset_cond = !reset_pulse_pin_n || power_down_threshold || !supplies_good;

   // [R18] delayed release after supplies
   fblc_sync_timer #(.DELAY(SYNC_DELAY)) u_timer
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .hold      (reset_cond),
      .release_o (released)
   );

   fblc_flag_array #(.NUM_BLOCKS(NUM_BLOCKS), .AW(AW)) u_arr
   (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .cif     (cif)
   );

   // ************************************************************
   // command routing into the flag array
   // ************************************************************
   logic is_lockcmd;
   assign is_lockcmd = (cmd_code == FBLC_CMD_LOCK) || (cmd_code == FBLC_CMD_UNLOCK)
                    || (cmd_code == FBLC_CMD_LOCKDOWN);
   // [R14] [R16] [R17] lock allowed unless program suspended
   assign cif.cmd_valid  = cmd_valid && is_lockcmd && !reset_cond
                        && (suspend_state != FBLC_SUSP_PROG);
   assign cif.cmd_code   = cmd_code;
   assign cif.cmd_block  = cmd_valid ? cmd_block : s_q.pend_blk;
   assign cif.wp_high    = s_q.wp_s;
   // [R21] edges from sampled level
   assign cif.wp_rise    = s_q.wp_s && !s_q.wp_prev;
   assign cif.wp_fall    = !s_q.wp_s && s_q.wp_prev;
   // [R13] reset forces locked
   assign cif.soft_reset = reset_cond;

   // next state of control
   always_comb
   begin
      s_d         = s_q;
      s_d.wp_prev = s_q.wp_s;
      s_d.wp_s    = write_protect_n;
      s_d.grant   = 1'b0;
      s_d.ign     = 1'b0;
      s_d.sync    = released && !reset_cond;
      // program/erase waits one cycle for the flag lookup
      s_d.pend    = cmd_valid && !reset_cond
                 && (cmd_code == FBLC_CMD_PROGRAM || cmd_code == FBLC_CMD_ERASE);
      s_d.pend_code = cmd_code;
      if (cmd_valid)
         s_d.pend_blk = cmd_block;
      if (s_q.pend)
      begin
         // [R7] unlocked block granted
         if (!cif.st_lock)
            s_d.grant = 1'b1;
         // [R6] locked block refused with error
         else
            s_d.err = 1'b1;
      end
      // [R17] lock command refused while program suspended
      if (cmd_valid && is_lockcmd && !reset_cond && (suspend_state == FBLC_SUSP_PROG))
         s_d.ign = 1'b1;
      // error cleared on reset condition
      if (reset_cond)
         s_d.err = 1'b0;
      // [R2] flags shown in signature mode
      if (sig_read_mode)
         s_d.stat = {s_q.wp_s, cif.st_ldown, cif.st_lock};
      else
         s_d.stat = 3'h0;
   end

   // control registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q         <= '0;
         // pin idles high, so no false edge right after reset
         s_q.wp_s    <= 1'b1;
         s_q.wp_prev <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // outputs straight from flops
   assign config_sync  = s_q.sync;
   assign op_grant     = s_q.grant;
   assign op_error     = s_q.err;
   assign lock_ignored = s_q.ign;
   assign status_word  = s_q.stat;
endmodule
`default_nettype wire

// ### verif/fblc_top_props.sv
// checker bound to the block lock control top
`timescale 1ns/100ps
`default_nettype none
module fblc_top_props
   import fblc_pkg::*;
#(
   parameter int unsigned SYNC_DELAY = 4
)
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // watched ports
   input wire logic       reset_pulse_pin_n,
   input wire logic       supplies_good,
   input wire logic       power_down_threshold,
   input wire logic       config_sync,
   input wire logic       cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [1:0] suspend_state,
   input wire logic       sig_read_mode,
   input wire logic       op_grant,
   input wire logic       op_error,
   input wire logic       lock_ignored,
   input wire logic [2:0] status_word
);
   logic       rc;
   logic       op_req;
   logic       lk_req;
   logic [7:0] cnt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // request decode, reset condition blocks every request
   assign rc     = !reset_pulse_pin_n || power_down_threshold || !supplies_good;
   assign op_req = cmd_valid && !rc && (cmd_code == 3'h4 || cmd_code == 3'h5);
   assign lk_req = cmd_valid && !rc && (cmd_code inside {3'h1, 3'h2, 3'h3});
   // cycles since the reset condition went away
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 8'h00;
      else if (rc)
         cnt_q <= 8'h00;
      else if (cnt_q != 8'hff)
         cnt_q <= cnt_q + 8'h01;
   end
   sequence s_op_taken;
      op_req ##1 !rc;
   endsequence
   sequence s_rd_off;
      !sig_read_mode ##1 !sig_read_mode ##1 !sig_read_mode;
   endsequence
   sync_low_a:
      assert property (rc |=> !config_sync) else $error("sync pin high in reset");
   sync_delay_a:
      assert property ($rose(config_sync) |-> cnt_q >= SYNC_DELAY)
         else $error("sync pin released early");
   op_answer_a:
      assert property (s_op_taken |=> op_grant || op_error) else $error("no answer");
   grant_cause_a:
      assert property (op_grant |-> $past(op_req, 2)) else $error("grant without request");
   grant_pulse_a:
      assert property (op_grant |=> !op_grant) else $error("grant too long");
   err_cause_a:
      assert property ($rose(op_error) |-> $past(op_req, 2)) else $error("stray error");
   err_sticky_a:
      assert property (op_error && !rc |=> op_error) else $error("error dropped");
   err_clear_a:
      assert property (rc |=> !op_error) else $error("error kept in reset");
   ign_hit_a:
      assert property (lk_req && suspend_state == 2'h2 |=> lock_ignored)
         else $error("lock in program suspend not refused");
   ign_cause_a:
      assert property (lock_ignored |-> $past(lk_req) && $past(suspend_state) == 2'h2)
         else $error("stray refusal");
   stat_idle_a:
      assert property (s_rd_off |-> status_word == 3'h0) else $error("status outside read");
endmodule
bind fblc_top fblc_top_props #(.SYNC_DELAY(SYNC_DELAY)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .reset_pulse_pin_n(reset_pulse_pin_n),
   .supplies_good(supplies_good), .power_down_threshold(power_down_threshold),
   .config_sync(config_sync), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .suspend_state(suspend_state), .sig_read_mode(sig_read_mode), .op_grant(op_grant),
   .op_error(op_error), .lock_ignored(lock_ignored), .status_word(status_word));
`default_nettype wire

// ### verif/fblc_host.sv
// model of the external master issuing flash commands
`timescale 1ns/100ps
`default_nettype none
module fblc_host
(
   // clock
   input  wire logic       ref_clk,
   // command port
   output var  logic       cmd_valid,
   output var  logic [2:0] cmd_code,
   output var  logic [7:0] cmd_block,
   output var  logic [1:0] suspend_state
);
   // idle port at time zero
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      cmd_block = 8'h00;
      suspend_state = 2'h0;
   end
   // one command cycle, fields inverted once released
   task automatic issue(input logic [2:0] code, input logic [7:0] blk);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_block = blk;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_block = ~blk;
   endtask
   task automatic suspend(input logic [1:0] s);
      @(negedge ref_clk);
      suspend_state = s;
      @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ### verif/flash_block_lock_control_test.sv
// self-checking bench of the block lock control
`timescale 1ns/100ps
`default_nettype none
module flash_block_lock_control_test;
   import fblc_pkg::*;
   localparam int SYNC_DLY = 4;
   typedef struct packed {logic wp; logic [2:0] code; logic [7:0] blk;
                          logic [2:0] st; logic g;} fblc_row_t;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       wp_n = 1'b1;
   logic       rp_n = 1'b1;
   logic       sup_ok = 1'b1;
   logic       pd = 1'b0;
   logic       rd_mode = 1'b0;
   logic       c_valid, sync, grant, err, ign;
   logic [2:0] c_code, stat;
   logic [7:0] c_blk;
   logic [1:0] susp;
   int         error_cnt = 0;
   int         num_checks = 0;
   fblc_row_t  rows [17] = '{
      '{1'b1, 3'h0, 8'h05, 3'h5, 1'b0}, // locked after reset
      '{1'b1, 3'h4, 8'h05, 3'h5, 1'b0}, // program refused
      '{1'b1, 3'h2, 8'h05, 3'h4, 1'b0}, // unlock
      '{1'b1, 3'h5, 8'h05, 3'h4, 1'b1}, // erase accepted
      '{1'b0, 3'h4, 8'h05, 3'h0, 1'b1}, // pin low program
      '{1'b0, 3'h1, 8'h05, 3'h1, 1'b0}, // lock
      '{1'b0, 3'h3, 8'h05, 3'h3, 1'b0}, // lockdown
      '{1'b0, 3'h2, 8'h05, 3'h3, 1'b0}, // frozen unlock
      '{1'b0, 3'h5, 8'h05, 3'h3, 1'b0}, // frozen erase
      '{1'b1, 3'h2, 8'h05, 3'h6, 1'b0}, // unlock keeps lockdown
      '{1'b1, 3'h4, 8'h05, 3'h6, 1'b1}, // program on unlocked lockdown
      '{1'b1, 3'h1, 8'h05, 3'h7, 1'b0}, // relock
      '{1'b1, 3'h2, 8'h05, 3'h6, 1'b0}, // unlock again
      '{1'b0, 3'h0, 8'h05, 3'h3, 1'b0}, // pin low relocks
      '{1'b0, 3'h0, 8'h06, 3'h1, 1'b0}, // other block untouched
      '{1'b1, 3'h0, 8'h05, 3'h6, 1'b0}, // restore on rise
      '{1'b1, 3'h0, 8'h06, 3'h5, 1'b0}  // other block own state
   };
   always #20 ref_clk = ~ref_clk;
   fblc_host u_fblc_host (.ref_clk(ref_clk), .cmd_valid(c_valid), .cmd_code(c_code),
      .cmd_block(c_blk), .suspend_state(susp));
   fblc_top #(.SYNC_DELAY(SYNC_DLY)) u_fblc_top (.ref_clk(ref_clk), .rst_n(rst_n),
      .write_protect_n(wp_n), .reset_pulse_pin_n(rp_n), .supplies_good(sup_ok),
      .power_down_threshold(pd), .config_sync(sync), .cmd_valid(c_valid),
      .cmd_code(c_code), .cmd_block(c_blk), .suspend_state(susp),
      .sig_read_mode(rd_mode), .op_grant(grant), .op_error(err),
      .lock_ignored(ign), .status_word(stat));
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t flag got %b want %b", $time, got, exp);
      end
   endtask
   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t status got %b want %b", $time, got, exp);
      end
   endtask
   // command, then one edge: status settled and grant pulse still standing
   task automatic step(input logic [2:0] code, input logic [7:0] blk);
      u_fblc_host.issue(code, blk);
      @(posedge ref_clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog against a hung run
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      error_cnt++;
      test_done();
   end
   initial
   begin
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (SYNC_DLY + 4) @(negedge ref_clk);
      chk1(sync, 1'b1);
      chk3(stat, 3'h0);
      rd_mode = 1'b1;
      foreach (rows[i])
      begin
         @(negedge ref_clk);
         wp_n = rows[i].wp;
         repeat (4) @(negedge ref_clk);
         step(rows[i].code, rows[i].blk);
         chk3(stat, rows[i].st);
         if (rows[i].code >= 3'h4)
         begin
            chk1(grant, rows[i].g);
            chk1(err | rows[i].g, 1'b1);
         end
      end
      $display("table rows done");
      u_fblc_host.suspend(2'h1);
      step(FBLC_CMD_UNLOCK, 8'h06);
      chk3(stat, 3'h4);
      step(FBLC_CMD_LOCKDOWN, 8'h06);
      chk3(stat, 3'h7);
      $display("erase suspend done");
      u_fblc_host.suspend(2'h2);
      u_fblc_host.issue(FBLC_CMD_UNLOCK, 8'h06);
      chk1(ign, 1'b1);
      step(FBLC_CMD_NONE, 8'h06);
      chk3(stat, 3'h7);
      u_fblc_host.suspend(2'h0);
      $display("program suspend done");
      for (int k = 0; k < 3; k++)
      begin
         @(negedge ref_clk);
         rp_n = (k != 0);
         pd = (k == 1);
         sup_ok = (k != 2);
         repeat (2) @(negedge ref_clk);
         chk1(sync, 1'b0);
         chk1(err, 1'b0);
         rp_n = 1'b1;
         pd = 1'b0;
         sup_ok = 1'b1;
         step(FBLC_CMD_NONE, 8'h05);
         chk3(stat, 3'h5);
         chk1(sync, 1'b0);
         repeat (SYNC_DLY + 2) @(posedge ref_clk);
         #1;
         chk1(sync, 1'b1);
      end
      @(negedge ref_clk);
      rd_mode = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk3(stat, 3'h0);
      $display("reset conditions done");
      test_done();
   end
endmodule
`default_nettype wire
